// ---- src/timer_family_pkg.sv ----
// Shared types and constants for the configurable timer family.
// Assumes one clock domain; configuration arrives as plain ports.
`default_nettype none
package timer_family_pkg;
   localparam int SYNC_STAGES = 3;
   localparam int DT_W = 8;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   localparam logic [DT_W-1:0] DT_RST = 8'h00;

   typedef enum logic [2:0] {CNT_UP = 3'b001, CNT_DOWN = 3'b010, CNT_CENTRE = 3'b100} cnt_mode_t;
   typedef enum logic [3:0] {
      TRG_NONE = 4'b0001, TRG_RESTART = 4'b0010, TRG_GATE = 4'b0100, TRG_CLOCK = 4'b1000
   } trg_mode_t;
   typedef enum logic [4:0] {
      CH_OFF = 5'b00001, CH_CAPTURE = 5'b00010, CH_COMPARE = 5'b00100, CH_PWM = 5'b01000, CH_PULSE = 5'b10000
   } ch_mode_t;

   typedef struct packed {
      logic enable;
      logic onePulse;
      logic encoder;
      logic pllClk;
      logic dbgFreeze;
      logic dmaEn;
      logic outEn;
      cnt_mode_t cntMode;
      trg_mode_t trgMode;
      logic [DT_W-1:0] deadTime;
      logic [31:0] psc;
      logic [31:0] arr;
   } tim_cfg_t;

   typedef struct packed {
      ch_mode_t mode;
      logic [31:0] cmp;
   } ch_cfg_t;

   typedef struct packed {
      logic upd;
      logic trgOut;
      logic dma;
      logic adcReg;
      logic adcInj;
      logic dac;
   } tim_evt_t;
endpackage
`default_nettype wire

// ---- src/timer_unit.sv ----
// Parameterised timer covering the advanced, general, mid-range and basic variants.
// Assumes pins are asynchronous; trigger link and debug halt share clk.
`default_nettype none

module pin_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r, qNxt;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         qNxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= qNxt;
      end
   end
   assign q = q_r;
endmodule

module timer_unit
   import timer_family_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int PSC_W = 16,
   parameter int NUM_CH = 4,
   parameter bit CH_EN = 1'b1,
   parameter bit UPDOWN = 1'b1,
   parameter bit HAS_ENC = 1'b1,
   parameter bit HAS_COMP = 1'b0,
   parameter bit ADV = 1'b0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire tim_cfg_t cfg,
   input wire ch_cfg_t chCfg [NUM_CH],
   input wire logic trgIn,
   input wire logic pllTick,
   input wire logic [NUM_CH-1:0] capPin,
   input wire logic encA,
   input wire logic encB,
   input wire logic debugHalt,
   input wire logic updClr,
   input wire logic [NUM_CH-1:0] ccClr,
   output logic [CNT_W-1:0] count,
   output logic countDown,
   output logic running,
   output logic updFlag,
   output logic [NUM_CH-1:0] ccFlag,
   output logic [NUM_CH-1:0][CNT_W-1:0] capVal,
   output logic [NUM_CH-1:0] chOut,
   output logic chOutN,
   output tim_evt_t evt
);
   logic [NUM_CH+2:0] pinQ;
   logic [NUM_CH+2:0] pinPrev_r;
   logic [CNT_W-1:0] cnt_r, cntNxt, arrV;
   logic [PSC_W-1:0] psc_r, pscNxt, pscV;
   logic down_r, downNxt, run_r, runNxt, enPrev_r, updNow;
   logic freeze, srcEv, gateOk, advance, tick, goDown, aQ, bQ, pllQ, encEdge, pllEdge;

   pin_sync3 #(.W(NUM_CH + 3)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({pllTick, encB, encA, capPin}),
      .q(pinQ)
   );

   assign aQ = pinQ[NUM_CH];
   assign bQ = pinQ[NUM_CH+1];
   assign pllQ = pinQ[NUM_CH+2];
   assign encEdge = aQ ^ pinPrev_r[NUM_CH];
   assign pllEdge = pllQ & ~pinPrev_r[NUM_CH+2];
   assign arrV = cfg.arr[CNT_W-1:0];
   assign pscV = cfg.psc[PSC_W-1:0];
   assign freeze = debugHalt & cfg.dbgFreeze;

   always_comb begin
      if (HAS_ENC && cfg.encoder) begin
         srcEv = encEdge;
      end else if (cfg.trgMode == TRG_CLOCK) begin
         srcEv = trgIn;
      end else if (ADV && cfg.pllClk) begin
         srcEv = pllEdge;
      end else begin
         srcEv = 1'b1;
      end
      gateOk = (cfg.trgMode != TRG_GATE) || trgIn;
      advance = run_r & srcEv & gateOk & ~freeze;
      tick = advance && (psc_r == pscV);
      if (HAS_ENC && cfg.encoder) begin
         goDown = (aQ == bQ);
      end else begin
         goDown = UPDOWN && ((cfg.cntMode == CNT_DOWN) || (cfg.cntMode == CNT_CENTRE && down_r));
      end
   end

   always_comb begin
      cntNxt = cnt_r;
      downNxt = down_r;
      pscNxt = psc_r;
      runNxt = run_r;
      updNow = 1'b0;
      if (advance) begin
         pscNxt = tick ? '0 : psc_r + 1'b1;
      end
      if (tick) begin
         if (UPDOWN && !cfg.encoder && cfg.cntMode == CNT_CENTRE) begin
            if (!down_r) begin
               if (cnt_r >= arrV) begin
                  downNxt = 1'b1;
                  cntNxt = (arrV != '0) ? arrV - 1'b1 : '0;
                  updNow = 1'b1;
               end else begin
                  cntNxt = cnt_r + 1'b1;
               end
            end else if (cnt_r == '0) begin
               downNxt = 1'b0;
               cntNxt = (arrV != '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
               updNow = 1'b1;
            end else begin
               cntNxt = cnt_r - 1'b1;
            end
         end else if (goDown) begin
            if (cnt_r == '0) begin
               cntNxt = arrV;
               updNow = 1'b1;
            end else begin
               cntNxt = cnt_r - 1'b1;
            end
         end else if (cnt_r >= arrV) begin
            cntNxt = '0;
            updNow = 1'b1;
         end else begin
            cntNxt = cnt_r + 1'b1;
         end
      end
      if (updNow && cfg.onePulse && !cfg.encoder) begin
         runNxt = 1'b0;
      end
      if (cfg.enable && !enPrev_r) begin
         runNxt = 1'b1;
      end
      if (cfg.enable && cfg.trgMode == TRG_RESTART && trgIn && !freeze) begin
         cntNxt = goDown ? arrV : '0;
         pscNxt = '0;
         downNxt = 1'b0;
         runNxt = 1'b1;
         updNow = 1'b1;
      end
      if (!cfg.enable) begin
         runNxt = 1'b0;
         pscNxt = '0;
         updNow = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= CNT_RST[CNT_W-1:0];
         psc_r <= '0;
         down_r <= 1'b0;
         run_r <= 1'b0;
         enPrev_r <= 1'b0;
         pinPrev_r <= '0;
      end else begin
         cnt_r <= cntNxt;
         psc_r <= pscNxt;
         down_r <= downNxt;
         run_r <= runNxt;
         enPrev_r <= cfg.enable;
         pinPrev_r <= pinQ;
      end
   end

   logic [NUM_CH-1:0] ref_r, refNxt, ccSet, flag_r, flagNxt, out_r, outNxt;
   logic [NUM_CH-1:0][CNT_W-1:0] cap_r, capNxt;

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [CNT_W-1:0] cmpV;
      logic match, capEdge;
      assign cmpV = chCfg[i].cmp[CNT_W-1:0];
      assign match = tick && (cnt_r == cmpV);
      assign capEdge = pinQ[i] & ~pinPrev_r[i];
      always_comb begin
         refNxt[i] = 1'b0;
         ccSet[i] = 1'b0;
         capNxt[i] = cap_r[i];
         if (CH_EN) begin
            unique case (chCfg[i].mode)
               CH_OFF: refNxt[i] = 1'b0;
               CH_CAPTURE: begin
                  ccSet[i] = capEdge;
                  capNxt[i] = capEdge ? cnt_r : cap_r[i];
               end
               CH_COMPARE: begin
                  ccSet[i] = match;
                  refNxt[i] = ref_r[i] ^ match;
               end
               CH_PWM: begin
                  ccSet[i] = match;
                  refNxt[i] = cfg.enable && (cnt_r < cmpV);
               end
               CH_PULSE: begin
                  ccSet[i] = match;
                  refNxt[i] = run_r && (cnt_r >= cmpV);
               end
               default: refNxt[i] = 1'b0;
            endcase
         end
         flagNxt[i] = ccSet[i] | (flag_r[i] & ~ccClr[i]);
      end
   end

   logic [DT_W-1:0] dt_r, dtNxt;
   logic refPrev_r, outN_r, outNNxt, updFlag_r, updFlagNxt, offForce;
   tim_evt_t evt_r, evtNxt;

   always_comb begin
      offForce = !cfg.outEn || (ADV && freeze);
      dtNxt = dt_r;
      if (HAS_COMP) begin
         if (ref_r[0] != refPrev_r) begin
            dtNxt = cfg.deadTime;
         end else if (dt_r != '0) begin
            dtNxt = dt_r - 1'b1;
         end
      end
      outNxt = offForce ? '0 : ref_r;
      outNNxt = 1'b0;
      if (HAS_COMP && !offForce) begin
         outNxt[0] = ref_r[0] && (dtNxt == '0);
         outNNxt = !ref_r[0] && (dtNxt == '0) && cfg.enable;
      end
      updFlagNxt = updNow | (updFlag_r & ~updClr);
      evtNxt.upd = updNow;
      evtNxt.trgOut = updNow;
      evtNxt.dma = cfg.dmaEn && (updNow || (ccSet != '0));
      evtNxt.adcReg = updNow;
      evtNxt.adcInj = ADV && (updNow || (ccSet != '0));
      evtNxt.dac = updNow;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_r <= '0;
         flag_r <= '0;
         cap_r <= '0;
         out_r <= '0;
         outN_r <= 1'b0;
         dt_r <= DT_RST;
         refPrev_r <= 1'b0;
         updFlag_r <= 1'b0;
         evt_r <= '0;
      end else begin
         ref_r <= refNxt;
         flag_r <= flagNxt;
         cap_r <= capNxt;
         out_r <= outNxt;
         outN_r <= outNNxt;
         dt_r <= dtNxt;
         refPrev_r <= ref_r[0];
         updFlag_r <= updFlagNxt;
         evt_r <= evtNxt;
      end
   end

   assign count = cnt_r;
   assign countDown = goDown;
   assign running = run_r;
   assign updFlag = updFlag_r;
   assign ccFlag = flag_r;
   assign capVal = cap_r;
   assign chOut = out_r;
   assign chOutN = outN_r;
   assign evt = evt_r;

   a_psc_tick: assert property (@(posedge clk) disable iff (!arst_n)
      tick |-> psc_r == pscV && advance) else $error("Tick without full prescale");
   a_up_reload: assert property (@(posedge clk) disable iff (!arst_n)
      tick && !goDown && cfg.cntMode == CNT_UP && cnt_r >= arrV && cfg.enable && trgIn == 1'b0
      |=> cnt_r == '0 && updFlag_r) else $error("Up reload missing");
   a_freeze_hold: assert property (@(posedge clk) disable iff (!arst_n)
      freeze && $past(freeze) && cfg.enable && cfg.trgMode != TRG_RESTART |=> $stable(cnt_r))
      else $error("Counter moved while frozen");
   a_freeze_off: assert property (@(posedge clk) disable iff (!arst_n)
      ADV && freeze |=> out_r == '0 && !outN_r) else $error("Outputs live while frozen");
   a_dead_gap: assert property (@(posedge clk) disable iff (!arst_n)
      HAS_COMP && $rose(out_r[0]) |-> !$past(outN_r) && !outN_r) else $error("Pair overlap");
   a_pair_excl: assert property (@(posedge clk) disable iff (!arst_n)
      !(out_r[0] && outN_r && HAS_COMP)) else $error("Both pair outputs high");
   a_one_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      updNow && cfg.onePulse && !cfg.encoder && cfg.trgMode != TRG_RESTART && $stable(cfg.enable)
      |=> !run_r) else $error("One-pulse did not stop");
   a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      updFlag_r && !updClr |=> updFlag_r) else $error("Update flag lost");
   a_evt_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      evt_r.upd |-> $past(updNow) && evt_r.dac && evt_r.adcReg && evt_r.trgOut)
      else $error("Event outputs disagree");
   a_centre_turn: assert property (@(posedge clk) disable iff (!arst_n)
      UPDOWN && tick && cfg.cntMode == CNT_CENTRE && !cfg.encoder && !down_r && cnt_r >= arrV
      && cfg.trgMode != TRG_RESTART ##1 cfg.enable |-> down_r) else $error("Centre did not turn");
   a_up_only: assert property (@(posedge clk) disable iff (!arst_n)
      !UPDOWN && !HAS_ENC |-> !goDown) else $error("Up-only variant counted down");
endmodule
`default_nettype wire

// ---- verif/power_stage_model.sv ----
// Model of the power stage, capture pins and encoder that face one timer.
// Assumes clk is the timer clock; pins change just after rising edges.
`default_nettype none
module power_stage_model (
   input wire logic clk,
   input wire logic gateHi,
   input wire logic gateLo,
   output logic [3:0] capPin,
   output logic encA,
   output logic encB
);
   timeunit 1ns;
   timeprecision 1ps;
   int overlap, minGap, lowCnt, loRises, ph;
   logic loPrev;
   initial begin
      capPin = 4'h0;
      encA = 1'b0;
      encB = 1'b0;
      loPrev = 1'b0;
   end
   // Both switches on together would short the supply
   always @(posedge clk) begin
      if (gateHi && gateLo) overlap++;
      if (!gateHi && !gateLo) lowCnt++;
      else begin
         if (lowCnt > 0 && lowCnt < minGap) minGap = lowCnt;
         lowCnt = 0;
      end
      if (gateLo && !loPrev) loRises++;
      loPrev = gateLo;
   end
   task automatic clear_stats();
      overlap = 0;
      minGap = 1000;
      lowCnt = 0;
      loRises = 0;
   endtask
   task automatic cap_edge(int i);
      @(posedge clk);
      capPin[i] <= 1'b1;
      repeat (6) @(posedge clk);
      capPin[i] <= 1'b0;
   endtask
   // Gray steps, each held six cycles; phase A leads when counting up
   task automatic quad(int n, bit up);
      repeat (n) begin
         @(posedge clk);
         ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
         encA <= (ph == 1 || ph == 2);
         encB <= (ph == 2 || ph == 3);
         repeat (5) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the advanced variant of the timer.
// Assumes the power stage model drives the capture and encoder pins; all else is driven here.
`default_nettype none
module tb_top import timer_family_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, trgIn, pllTick, debugHalt, updClr, encA, encB, countDown, running, updFlag, chOutN;
   logic [3:0] ccClr, capPin, ccFlag, chOut;
   logic [3:0][15:0] capVal;
   logic [15:0] count, c0, d;
   logic [31:0] ones;
   logic [31:0] dc [4] = '{32'h0, 32'h2, 32'h5, 32'h7};
   tim_cfg_t cfg;
   ch_cfg_t chCfg [4];
   tim_evt_t evt;
   int n_errors, tests_run;

   always #4 clk = ~clk;

   timer_unit #(.HAS_COMP(1'b1), .ADV(1'b1)) dut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .chCfg(chCfg),
      .trgIn(trgIn),
      .pllTick(pllTick), .capPin(capPin), .encA(encA), .encB(encB), .debugHalt(debugHalt), .updClr(updClr),
      .ccClr(ccClr), .count(count), .countDown(countDown), .running(running), .updFlag(updFlag),
      .ccFlag(ccFlag), .capVal(capVal), .chOut(chOut), .chOutN(chOutN), .evt(evt));

   power_stage_model ps (.clk(clk), .gateHi(chOut[0]), .gateLo(chOutN), .capPin(capPin), .encA(encA),
      .encB(encB));

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Reset, load mode and limits, then raise enable
   task automatic start(cnt_mode_t m, logic [31:0] p, logic [31:0] a);
      @(posedge clk);
      arst_n <= 1'b0;
      cfg.enable <= 1'b0;
      cfg.cntMode <= m;
      cfg.psc <= p;
      cfg.arr <= a;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      cfg.enable <= 1'b1;
      repeat (7) @(posedge clk);
   endtask

   // Each sampled count must follow from the one or two before it
   task automatic seq(cnt_mode_t m, logic [31:0] a);
      logic [31:0] s [16];
      logic [5:0] e [16];
      logic [31:0] x;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         s[i] = count;
         e[i] = {evt.upd, evt.dac, evt.dma, evt.adcInj, evt.trgOut, evt.adcReg};
      end
      for (int i = 1; i < 15; i++) begin
         if (m == CNT_UP) x = (s[i] == a) ? 32'h0 : s[i] + 32'h1;
         else if (m == CNT_DOWN) x = (s[i] == 32'h0) ? a : s[i] - 32'h1;
         else if (s[i] == a || s[i] == 32'h0) x = (s[i] == 32'h0) ? 32'h1 : a - 32'h1;
         else x = (s[i] > s[i-1]) ? s[i] + 32'h1 : s[i] - 32'h1;
         chk("count", x, s[i+1]);
         if (m == CNT_UP) chk("events", {26'h0, {6{s[i] == 32'h0}}}, e[i]);
      end
   endtask

   initial begin
      #400000;
      n_errors++;
      stop_test();
   end

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {trgIn, pllTick, debugHalt, updClr} = 4'h0;
      ccClr = 4'h0;
      cfg = '0;
      cfg.cntMode = CNT_UP;
      cfg.trgMode = TRG_NONE;
      cfg.dmaEn = 1'b1;
      cfg.outEn = 1'b1;
      for (int i = 0; i < 4; i++) chCfg[i] = '{CH_OFF, 32'h0};
      start(CNT_UP, 32'h0, 32'h2);
      seq(CNT_UP, 32'h2);
      @(posedge clk);
      cfg.enable <= 1'b0;
      repeat (3) @(posedge clk);
      updClr <= 1'b1;
      @(posedge clk);
      updClr <= 1'b0;
      @(negedge clk);
      chk("updFlag", 32'h0, updFlag);
      start(CNT_DOWN, 32'h0, 32'h5);
      seq(CNT_DOWN, 32'h5);
      start(CNT_CENTRE, 32'h0, 32'h3);
      seq(CNT_CENTRE, 32'h3);
      start(CNT_UP, 32'h3, 32'hFFFF);
      @(negedge clk) c0 = count;
      repeat (40) @(negedge clk);
      chk("prescale", c0 + 16'hA, count);
      start(CNT_UP, 32'h0, 32'h4);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         chCfg[1] <= '{CH_PWM, dc[k]};
         repeat (8) @(negedge clk);
         ones = 32'h0;
         repeat (5) @(negedge clk) ones = ones + chOut[1];
         chk("duty", (dc[k] > 32'h5) ? 32'h5 : dc[k], ones);
      end
      @(posedge clk);
      cfg.dbgFreeze <= 1'b1;
      debugHalt <= 1'b1;
      repeat (4) @(negedge clk);
      c0 = count;
      repeat (6) @(negedge clk);
      chk("frozen", c0, count);
      chk("outputs off", 32'h0, {chOut, chOutN});
      @(posedge clk);
      debugHalt <= 1'b0;
      repeat (4) @(negedge clk);
      chk("resumed", 32'h1, chOut[1]);
      @(posedge clk);
      cfg.deadTime <= 8'h03;
      chCfg[0] <= '{CH_PWM, 32'h5};
      start(CNT_UP, 32'h0, 32'h9);
      ps.clear_stats();
      repeat (40) @(negedge clk);
      chk("overlap", 32'h0, ps.overlap);
      chk("dead gap", 32'h3, ps.minGap);
      chk("complement", 32'h1, ps.loRises > 1);
      @(posedge clk);
      chCfg[2] <= '{CH_CAPTURE, 32'h0};
      start(CNT_UP, 32'h0, 32'hFFFF);
      @(negedge clk) c0 = count;
      ps.cap_edge(2);
      d = capVal[2] - c0;
      chk("capture", 32'h1, ccFlag[2] && d >= 16'h2 && d <= 16'h7);
      ccClr <= 4'h4;
      @(posedge clk);
      ccClr <= 4'h0;
      @(negedge clk);
      chk("ccFlag", 32'h0, ccFlag[2]);
      @(posedge clk);
      cfg.encoder <= 1'b1;
      start(CNT_UP, 32'h0, 32'hFFFF);
      @(negedge clk) c0 = count;
      ps.quad(8, 1'b1);
      repeat (8) @(negedge clk);
      chk("encoder up", c0 + 16'h4, count);
      ps.quad(8, 1'b0);
      repeat (8) @(negedge clk);
      chk("encoder down", {c0, countDown}, {count, 1'b1});
      @(posedge clk);
      cfg.encoder <= 1'b0;
      cfg.trgMode <= TRG_RESTART;
      start(CNT_UP, 32'h0, 32'hFFFF);
      repeat (20) @(negedge clk);
      @(posedge clk);
      trgIn <= 1'b1;
      @(posedge clk);
      trgIn <= 1'b0;
      repeat (3) @(negedge clk);
      chk("restart", 32'h1, count <= 16'h4 && updFlag);
      @(posedge clk);
      cfg.trgMode <= TRG_CLOCK;
      start(CNT_UP, 32'h0, 32'hFFFF);
      @(negedge clk) c0 = count;
      @(posedge clk);
      trgIn <= 1'b1;
      repeat (5) @(posedge clk);
      trgIn <= 1'b0;
      repeat (4) @(negedge clk);
      chk("chained", c0 + 16'h5, count);
      @(posedge clk);
      cfg.trgMode <= TRG_NONE;
      cfg.pllClk <= 1'b1;
      start(CNT_UP, 32'h0, 32'hFFFF);
      @(negedge clk) c0 = count;
      @(posedge clk);
      repeat (3) begin
         pllTick <= 1'b1;
         repeat (5) @(posedge clk);
         pllTick <= 1'b0;
         repeat (5) @(posedge clk);
      end
      repeat (6) @(negedge clk);
      chk("pll ticks", c0 + 16'h3, count);
      // One period then stop; compare and pulse channels see each count once
      @(posedge clk);
      cfg.pllClk <= 1'b0;
      cfg.onePulse <= 1'b1;
      chCfg[1] <= '{CH_COMPARE, 32'h2};
      chCfg[3] <= '{CH_PULSE, 32'h3};
      start(CNT_UP, 32'h0, 32'h5);
      repeat (10) @(negedge clk);
      chk("one pulse", 32'h0, {count, running});
      chk("one pulse chans", 32'hB3, {ccFlag, chOut});
      @(posedge clk);
      cfg.onePulse <= 1'b0;
      cfg.trgMode <= TRG_GATE;
      start(CNT_UP, 32'h0, 32'hFFFF);
      trgIn <= 1'b1;
      repeat (4) @(posedge clk);
      trgIn <= 1'b0;
      repeat (4) @(negedge clk);
      chk("gated", 32'h4, count);
      stop_test();
   end
endmodule
`default_nettype wire
